//--- verilog/rod_pkg.sv
// shared constants, encodings and carriers for the register-op decoder
package rod_pkg;
   //----------------------------------------------------------------
   // widths and timing
   //----------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int IMM_W = 15;
   localparam int CHAR_W = 17;
   localparam int CNT_W = 16;
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_SHORT_NS = 1300;   // enter, increase, xor, and
   localparam int T_SKIP_NS = 1900;    // compare-and-skip, index step
   localparam int T_IND_NS = 1250;     // one indirect step
   localparam int T_SEARCH_NS = 4200;  // search setup and per word
   localparam int SHORT_CYC = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SKIP_CYC = (T_SKIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IND_CYC = (T_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEARCH_CYC = (T_SEARCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   //----------------------------------------------------------------
   // instruction fields
   //----------------------------------------------------------------
   localparam int FC_HI = 23;
   localparam int FC_LO = 18;
   localparam int SEXT_BIT = 17;
   localparam int VAR_HI = 17;
   localparam int VAR_LO = 15;
   localparam int IDX_HI = 16;
   localparam int IDX_LO = 15;

   // function codes (octal 04,05,10,11,14,15,16,17 written in hex)
   localparam logic [5:0] FC_EQ_SKIP = 6'h04;
   localparam logic [5:0] FC_GE_SKIP = 6'h05;
   localparam logic [5:0] FC_IDX_STEP = 6'h08;
   localparam logic [5:0] FC_CHAR_LOAD = 6'h09;
   localparam logic [5:0] FC_ENTER = 6'h0c;
   localparam logic [5:0] FC_INCREASE = 6'h0d;
   localparam logic [5:0] FC_XOR = 6'h0e;
   localparam logic [5:0] FC_AND = 6'h0f;
   localparam logic [5:0] FC_HALT = 6'h00;
   localparam logic [5:0] FC_MASK_EQ = 6'h3a;
   localparam logic [5:0] FC_MASK_TH = 6'h3b;
   localparam logic [5:0] FC_EXT_IO = 6'h3f;
   localparam logic [5:0] FC_TRAP_LO = 6'h2d;  // octal 55
   localparam logic [5:0] FC_TRAP_HI = 6'h38;  // octal 70

   // variant sub-field: 0..3 index b, then A, Q, A sign-ext, Q sign-ext
   localparam logic [2:0] VAR_ACC = 3'h4;
   localparam logic [2:0] VAR_AUX = 3'h5;
   localparam logic [2:0] VAR_ACC_S = 3'h6;
   localparam logic [2:0] VAR_AUX_S = 3'h7;

   localparam logic [IMM_W-1:0] RESET_PC = 15'h0000;
   localparam logic [IMM_W-1:0] TRAP_VECTOR = 15'h0009;  // octal 00011
   localparam logic [IMM_W-1:0] IDX_ONE = 15'h0001;
   localparam logic [IMM_W-1:0] IDX_MINUS_ONE = 15'h7ffe;

   //----------------------------------------------------------------
   // types
   //----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_EQ_SKIP = 4'h0,
      OP_GE_SKIP = 4'h1,
      OP_LOAD = 4'h2,
      OP_CHAR = 4'h3,
      OP_ADD = 4'h4,
      OP_XOR = 4'h5,
      OP_AND = 4'h6,
      OP_IDX_STEP = 4'h7,
      OP_HALT = 4'h8,
      OP_EXT_IO = 4'h9,
      OP_SEARCH = 4'ha,
      OP_TRAPPED = 4'hb,
      OP_OTHER = 4'hc
   } rod_op_e;

   typedef enum logic [1:0] {
      TGT_ACC = 2'h0,
      TGT_AUX = 2'h1,
      TGT_IDX = 2'h2
   } rod_tgt_e;

   typedef struct packed {
      rod_op_e op;
      rod_tgt_e tgt;
      logic [1:0] bsel;
      logic sext;
      logic step_down;
      logic [WORD_W-1:0] imm24;
      logic [IMM_W-1:0] imm15;
      logic [CNT_W-1:0] base_cyc;
   } rod_dec_s;

   typedef struct packed {
      logic [WORD_W-1:0] acc;
      logic [WORD_W-1:0] aux;
      logic [IMM_W-1:0] idx3;
      logic [IMM_W-1:0] idx2;
      logic [IMM_W-1:0] idx1;
   } rod_regs_s;
endpackage

//--- verilog/rod_decode.sv
// instruction word decoder for the register-op group
`timescale 1ns/1ps
`default_nettype none
module rod_decode (
   // instruction in
   input wire logic [rod_pkg::WORD_W-1:0] i_instr,
   input wire logic i_opt_hw,
   // decoded out
   output rod_pkg::rod_dec_s o_dec
);
   import rod_pkg::*;

   logic [5:0] fc;
   logic [2:0] var_f;

   // field split, operand widening and class selection
   always_comb begin
      fc = i_instr[FC_HI:FC_LO];
      var_f = i_instr[VAR_HI:VAR_LO];
      o_dec = '0;
      o_dec.imm15 = i_instr[IMM_W-1:0];
      o_dec.bsel = i_instr[IDX_HI:IDX_LO];
      o_dec.base_cyc = CNT_W'(SHORT_CYC);
      // variant picks register and sign handling
      case (var_f)
         VAR_ACC: begin
            o_dec.tgt = TGT_ACC;
         end
         VAR_AUX: begin
            o_dec.tgt = TGT_AUX;
         end
         VAR_ACC_S: begin
            o_dec.tgt = TGT_ACC;
            o_dec.sext = 1'b1;
         end
         VAR_AUX_S: begin
            o_dec.tgt = TGT_AUX;
            o_dec.sext = 1'b1;
         end
         default: begin
            o_dec.tgt = TGT_IDX;
         end
      endcase
      case (fc)
         FC_EQ_SKIP: begin
            o_dec.op = OP_EQ_SKIP;
            o_dec.base_cyc = CNT_W'(SKIP_CYC);
         end
         FC_GE_SKIP: begin
            o_dec.op = OP_GE_SKIP;
            o_dec.base_cyc = CNT_W'(SKIP_CYC);
         end
         FC_ENTER: begin
            o_dec.op = OP_LOAD;
         end
         FC_INCREASE: begin
            o_dec.op = OP_ADD;
         end
         FC_XOR: begin
            o_dec.op = OP_XOR;
         end
         FC_AND: begin
            o_dec.op = OP_AND;
         end
         FC_CHAR_LOAD: begin
            o_dec.op = OP_CHAR;
            o_dec.tgt = TGT_ACC;
            o_dec.sext = i_instr[SEXT_BIT];
         end
         FC_IDX_STEP: begin
            o_dec.op = OP_IDX_STEP;
            o_dec.tgt = TGT_IDX;
            o_dec.step_down = i_instr[SEXT_BIT];
            o_dec.base_cyc = CNT_W'(SKIP_CYC);
         end
         FC_HALT: begin
            o_dec.op = OP_HALT;
         end
         FC_EXT_IO: begin
            o_dec.op = OP_EXT_IO;
         end
         FC_MASK_EQ, FC_MASK_TH: begin
            o_dec.op = OP_SEARCH;
            o_dec.base_cyc = CNT_W'(SEARCH_CYC);
         end
         default: begin
            if (fc >= FC_TRAP_LO && fc <= FC_TRAP_HI && !i_opt_hw) begin
               o_dec.op = OP_TRAPPED;
            end else begin
               o_dec.op = OP_OTHER;
            end
         end
      endcase
      // sign of y through the upper bits only when asked
      if (o_dec.op == OP_CHAR) begin
         o_dec.imm24 = o_dec.sext ?
            {{(WORD_W-CHAR_W){i_instr[CHAR_W-1]}}, i_instr[CHAR_W-1:0]} :
            {{(WORD_W-CHAR_W){1'b0}}, i_instr[CHAR_W-1:0]};
      end else begin
         o_dec.imm24 = o_dec.sext ?
            {{(WORD_W-IMM_W){i_instr[IMM_W-1]}}, i_instr[IMM_W-1:0]} :
            {{(WORD_W-IMM_W){1'b0}}, i_instr[IMM_W-1:0]};
      end
   end
endmodule
`default_nettype wire

//--- verilog/rod_core.sv
// register-op execution, timing model and next-instruction sequencing
//----------------------------------------------------------------------
// What this block does
// - add one storage cycle per indirect step
// - after each instruction, fetch next instruction
// - code 04 compares equal and skips
// - code 05 compares greater-or-equal and skips
// - code 11 loads 17-bit character address
// - code 16 xors immediate into register
// - code 17 ands immediate into register
// - code 10 index skip, step up/down
// - searches take setup plus per-word time
// - trap optional-hardware codes when hardware absent
// - external I/O waits for equipment response
// - halt stops; resume at held address
// - sign bit set extends immediate upward only in the sign-ext variants, and for code 11 when bit 17 is set
// - skip goes P+2, else P+1
// - index equal clears index before skip
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module rod_core #(
   parameter int IND_W = 4,
   parameter int WORDS_W = 16
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // instruction stream, same clock
   input wire logic i_instr_valid,
   input wire logic [rod_pkg::WORD_W-1:0] i_instr,
   input wire logic [IND_W-1:0] i_ind_steps,
   input wire logic [WORDS_W-1:0] i_search_words,
   // pins from outside the clock domain
   input wire logic i_opt_hw_present,
   input wire logic i_ext_resp,
   input wire logic i_restart,
   // status and results
   output logic o_fetch_req,
   output logic [rod_pkg::IMM_W-1:0] o_fetch_addr,
   output logic o_busy,
   output logic o_halted,
   output logic o_ext_wait,
   output logic o_trap,
   output rod_pkg::rod_regs_s o_regs
);
   import rod_pkg::*;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b000,
      ST_WAIT = 3'b001,
      ST_EXEC = 3'b010,
      ST_SEARCH = 3'b011,
      ST_EXT = 3'b100,
      ST_HALT = 3'b101
   } rod_state_e;

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   // one's complement add with end-around carry
   function automatic logic [WORD_W-1:0] oc_add24(input logic [WORD_W-1:0] a,
                                                  input logic [WORD_W-1:0] b);
      logic [WORD_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
   endfunction

   function automatic logic [IMM_W-1:0] oc_add15(input logic [IMM_W-1:0] a,
                                                 input logic [IMM_W-1:0] b);
      logic [IMM_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[IMM_W-1:0] + {{(IMM_W-1){1'b0}}, s[IMM_W]};
   endfunction

   // ordering key: flipped sign makes +0 rank above -0
   function automatic logic [WORD_W-1:0] oc_key24(input logic [WORD_W-1:0] a);
      return {~a[WORD_W-1], a[WORD_W-2:0]};
   endfunction

   function automatic logic [IMM_W-1:0] oc_key15(input logic [IMM_W-1:0] a);
      return {~a[IMM_W-1], a[IMM_W-2:0]};
   endfunction

   //----------------------------------------------------------------
   // pin synchronisers
   //----------------------------------------------------------------
   logic [2:0] sync1_ff, sync2_ff;
   logic restart_d_ff;
   logic opt_hw_s, ext_resp_s, restart_rise;

   // two stages per pin, plus a delay for the restart edge
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         restart_d_ff <= 1'b0;
      end else begin
         sync1_ff <= {i_restart, i_ext_resp, i_opt_hw_present};
         sync2_ff <= sync1_ff;
         restart_d_ff <= sync2_ff[2];
      end
   end
   assign opt_hw_s = sync2_ff[0];
   assign ext_resp_s = sync2_ff[1];
   assign restart_rise = sync2_ff[2] & ~restart_d_ff;

   //----------------------------------------------------------------
   // decode
   //----------------------------------------------------------------
   logic [WORD_W-1:0] instr_ff, nxt_instr;
   rod_dec_s dec;

   rod_decode u_decode (
      .i_instr(instr_ff),
      .i_opt_hw(opt_hw_s),
      .o_dec(dec)
   );

   //----------------------------------------------------------------
   // execute: result and skip for the held instruction
   //----------------------------------------------------------------
   rod_regs_s regs_ff, nxt_regs, res_regs;
   logic [IMM_W-1:0] idx_val, idx_res;
   logic [WORD_W-1:0] reg_val, reg_res;
   logic skip, idx_wr, eq_hit;

   always_comb begin
      res_regs = regs_ff;
      skip = 1'b0;
      idx_wr = (dec.bsel != 2'h0);  // index 0 reads zero, writes nothing
      case (dec.bsel)
         2'h1: idx_val = regs_ff.idx1;
         2'h2: idx_val = regs_ff.idx2;
         2'h3: idx_val = regs_ff.idx3;
         default: idx_val = '0;
      endcase
      reg_val = (dec.tgt == TGT_AUX) ? regs_ff.aux : regs_ff.acc;
      reg_res = reg_val;
      idx_res = idx_val;
      eq_hit = (idx_val == dec.imm15) ||
               ((&idx_val || idx_val == '0) && (&dec.imm15 || dec.imm15 == '0));
      case (dec.op)
         OP_EQ_SKIP: begin
            if (dec.tgt == TGT_IDX) skip = (idx_val == dec.imm15);
            else if (dec.sext) skip = (reg_val == dec.imm24);
            else skip = (reg_val[IMM_W-1:0] == dec.imm15);
         end
         OP_GE_SKIP: begin
            if (dec.tgt == TGT_IDX) skip = oc_key15(idx_val) >= oc_key15(dec.imm15);
            else if (dec.sext) skip = oc_key24(reg_val) >= oc_key24(dec.imm24);
            else skip = reg_val[IMM_W-1:0] >= dec.imm15;
         end
         OP_LOAD: begin
            reg_res = dec.imm24;
            idx_res = dec.imm15;
         end
         OP_CHAR: reg_res = dec.imm24;
         OP_ADD: begin
            reg_res = oc_add24(reg_val, dec.imm24);
            idx_res = oc_add15(idx_val, dec.imm15);
         end
         OP_XOR: begin
            reg_res = reg_val ^ dec.imm24;
            idx_res = idx_val ^ dec.imm15;
         end
         OP_AND: begin
            reg_res = reg_val & dec.imm24;
            idx_res = idx_val & dec.imm15;
         end
         OP_IDX_STEP: begin
            skip = eq_hit;
            if (eq_hit) idx_res = '0;
            else idx_res = oc_add15(idx_val, dec.step_down ? IDX_MINUS_ONE : IDX_ONE);
         end
         default: begin
         end
      endcase
      // write back to the chosen register
      if (dec.op inside {OP_LOAD, OP_CHAR, OP_ADD, OP_XOR, OP_AND, OP_IDX_STEP}) begin
         if (dec.tgt == TGT_ACC) res_regs.acc = reg_res;
         else if (dec.tgt == TGT_AUX) res_regs.aux = reg_res;
         else if (idx_wr && dec.bsel == 2'h1) res_regs.idx1 = idx_res;
         else if (idx_wr && dec.bsel == 2'h2) res_regs.idx2 = idx_res;
         else if (idx_wr) res_regs.idx3 = idx_res;
      end
   end

   //----------------------------------------------------------------
   // sequencer and timing model
   //----------------------------------------------------------------
   rod_state_e state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [WORDS_W-1:0] words_ff, nxt_words;
   logic [IMM_W-1:0] pc_ff, nxt_pc;
   logic fetch_ff, nxt_fetch, trap_ff, nxt_trap;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_words = words_ff;
      nxt_pc = pc_ff;
      nxt_instr = instr_ff;
      nxt_regs = regs_ff;
      nxt_fetch = 1'b0;
      nxt_trap = 1'b0;
      case (state_ff)
         ST_FETCH: begin
            nxt_fetch = 1'b1;
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_instr_valid) begin
               nxt_instr = i_instr;
               nxt_words = i_search_words;
               // base time is reloaded from decode on the next cycle
               nxt_cnt = CNT_W'(i_ind_steps) * CNT_W'(IND_CYC);
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // first cycle folds the base time into the indirect time
            if (cnt_ff[CNT_W-1] == 1'b0 && instr_ff == nxt_instr && cnt_ff != '1) begin
               nxt_cnt = '1 - (cnt_ff + dec.base_cyc) + CNT_W'(2);
            end
            if (cnt_ff == '1) begin
               case (dec.op)
                  OP_HALT: nxt_state = ST_HALT;
                  OP_EXT_IO: nxt_state = ST_EXT;
                  OP_SEARCH: begin
                     nxt_cnt = '1 - CNT_W'(SEARCH_CYC) + CNT_W'(1);
                     nxt_state = (words_ff == '0) ? ST_FETCH : ST_SEARCH;
                     if (words_ff == '0) nxt_pc = pc_ff + IDX_ONE;
                  end
                  OP_TRAPPED: begin
                     nxt_trap = 1'b1;
                     nxt_pc = TRAP_VECTOR;
                     nxt_state = ST_FETCH;
                  end
                  default: begin
                     nxt_regs = res_regs;
                     nxt_pc = pc_ff + (skip ? IDX_ONE + IDX_ONE : IDX_ONE);
                     nxt_state = ST_FETCH;
                  end
               endcase
            end else if (cnt_ff[CNT_W-1]) begin
               nxt_cnt = cnt_ff + CNT_W'(1);
            end
         end
         ST_SEARCH: begin
            // one word examined per search period
            if (cnt_ff == '1) begin
               nxt_words = words_ff - WORDS_W'(1);
               nxt_cnt = '1 - CNT_W'(SEARCH_CYC) + CNT_W'(1);
               if (words_ff == WORDS_W'(1)) begin
                  nxt_pc = pc_ff + IDX_ONE;
                  nxt_state = ST_FETCH;
               end
            end else begin
               nxt_cnt = cnt_ff + CNT_W'(1);
            end
         end
         ST_EXT: begin
            if (ext_resp_s) begin
               nxt_pc = pc_ff + IDX_ONE;
               nxt_state = ST_FETCH;
            end
         end
         ST_HALT: begin
            if (restart_rise) begin
               nxt_pc = instr_ff[IMM_W-1:0];
               nxt_state = ST_FETCH;
            end
         end
         default: nxt_state = ST_FETCH;
      endcase
   end

   // state registers
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= ST_FETCH;
         cnt_ff <= '0;
         words_ff <= '0;
         pc_ff <= RESET_PC;
         instr_ff <= '0;
         regs_ff <= '0;
         fetch_ff <= 1'b0;
         trap_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         words_ff <= nxt_words;
         pc_ff <= nxt_pc;
         instr_ff <= nxt_instr;
         regs_ff <= nxt_regs;
         fetch_ff <= nxt_fetch;
         trap_ff <= nxt_trap;
      end
   end

   //----------------------------------------------------------------
   // outputs, all from flip-flops
   //----------------------------------------------------------------
   logic busy_ff, halted_ff, ext_wait_ff;

   // registered status views
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_ff <= 1'b0;
         halted_ff <= 1'b0;
         ext_wait_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != ST_WAIT) && (nxt_state != ST_HALT);
         halted_ff <= (nxt_state == ST_HALT);
         ext_wait_ff <= (nxt_state == ST_EXT);
      end
   end

   assign o_fetch_req = fetch_ff;
   assign o_fetch_addr = pc_ff;
   assign o_busy = busy_ff;
   assign o_halted = halted_ff;
   assign o_ext_wait = ext_wait_ff;
   assign o_trap = trap_ff;
   assign o_regs = regs_ff;
endmodule
`default_nettype wire

//--- dv/rod_core_sva.sv
// concurrent checks on the register-op core ports
`timescale 1ns/1ps
`default_nettype none
module rod_core_sva (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_instr_valid,
   input wire logic i_opt_hw_present,
   input wire logic i_ext_resp,
   input wire logic i_restart,
   input wire logic o_fetch_req,
   input wire logic [rod_pkg::IMM_W-1:0] o_fetch_addr,
   input wire logic o_halted,
   input wire logic o_ext_wait,
   input wire logic o_trap
);
   import rod_pkg::*;
   //----------------------------------------------------------------
   // sequences and properties
   //----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   // fetch followed by a quiet instruction stream
   sequence s_quiet;
      o_fetch_req ##1 (!i_instr_valid && !i_restart) [*6];
   endsequence
   // equipment silent long enough to pass the synchroniser
   sequence s_resp_low;
      (!i_ext_resp) [*4];
   endsequence
   property p_fetch_pulse;
      o_fetch_req |=> !o_fetch_req;
   endproperty
   property p_no_spurious;
      s_quiet |-> !o_fetch_req;
   endproperty
   property p_addr_moves;
      $changed(o_fetch_addr) |-> ##[0:2] o_fetch_req;
   endproperty
   property p_ext_hold;
      s_resp_low ##0 o_ext_wait |=> o_ext_wait;
   endproperty
   property p_ext_cause;
      $fell(o_ext_wait) |-> $past(i_ext_resp, 2) || $past(i_ext_resp, 3) || $past(i_ext_resp, 4);
   endproperty
   property p_ext_fetch;
      $fell(o_ext_wait) |-> ##[0:5] o_fetch_req;
   endproperty
   property p_halt_quiet;
      o_halted |-> !o_fetch_req;
   endproperty
   property p_halt_resume;
      $fell(o_halted) |-> ##[0:5] o_fetch_req;
   endproperty
   property p_trap_vec;
      o_trap |-> ##[0:30] (o_fetch_req && o_fetch_addr == TRAP_VECTOR);
   endproperty
   property p_trap_pin;
      o_trap |-> !$past(i_opt_hw_present, 4);
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch too long");
   a_no_spurious: assert property (p_no_spurious) else $error("stray fetch");
   a_addr_moves: assert property (p_addr_moves) else $error("addr moved");
   a_ext_hold: assert property (p_ext_hold) else $error("wait ended early");
   a_ext_cause: assert property (p_ext_cause) else $error("wait ended unasked");
   a_ext_fetch: assert property (p_ext_fetch) else $error("no fetch after io");
   a_halt_quiet: assert property (p_halt_quiet) else $error("fetch in halt");
   a_halt_resume: assert property (p_halt_resume) else $error("no resume fetch");
   a_trap_vec: assert property (p_trap_vec) else $error("no trap vector");
   a_trap_pin: assert property (p_trap_pin) else $error("trap with hw");
endmodule
bind rod_core rod_core_sva i_sva (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
   .i_opt_hw_present(i_opt_hw_present), .i_ext_resp(i_ext_resp), .i_restart(i_restart),
   .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
   .o_halted(o_halted), .o_ext_wait(o_ext_wait), .o_trap(o_trap));
`default_nettype wire

//--- dv/rod_core_bench.sv
// self-checking bench for the register-op core
`timescale 1ns/1ps
`default_nettype none
module rod_core_bench;
   import rod_pkg::*;
   logic i_core_clk, i_rstn, i_instr_valid, i_opt_hw_present, i_ext_resp, i_restart;
   logic [WORD_W-1:0] i_instr;
   logic [3:0] i_ind_steps;
   logic [15:0] i_search_words;
   logic o_fetch_req, o_busy, o_halted, o_ext_wait, o_trap;
   logic [IMM_W-1:0] o_fetch_addr, p;
   rod_regs_s o_regs;
   int errors = 0;
   int samples_checked = 0;
   int nfetch = 0;
   int ntrap = 0;
   rod_core i_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_ind_steps(i_ind_steps), .i_search_words(i_search_words),
      .i_opt_hw_present(i_opt_hw_present), .i_ext_resp(i_ext_resp), .i_restart(i_restart),
      .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr), .o_busy(o_busy),
      .o_halted(o_halted), .o_ext_wait(o_ext_wait), .o_trap(o_trap), .o_regs(o_regs));
   // clock and pulse counters
   always #50 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      if (o_fetch_req) nfetch <= nfetch + 1;
      if (o_trap) ntrap <= ntrap + 1;
   end
   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   function automatic logic [23:0] w(input logic [5:0] f, input logic [2:0] v,
                                     input logic [14:0] y);
      return {f, v, y};
   endfunction
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic issue(input logic [23:0] wd, input logic [3:0] ind, input logic [15:0] nw);
      @(negedge i_core_clk);
      i_instr = wd;
      i_ind_steps = ind;
      i_search_words = nw;
      i_instr_valid = 1'b1;
      @(negedge i_core_clk);
      i_instr_valid = 1'b0;
   endtask
   task automatic wait_fetch(output int cyc);
      int n0;
      n0 = nfetch;
      cyc = 1;
      while (nfetch == n0 && cyc < 2000) begin
         @(negedge i_core_clk);
         cyc++;
      end
      chk("fetch seen", 24'h1, {23'h0, nfetch != n0});
   endtask
   // one instruction, its duration and its next address
   task automatic run(input logic [23:0] wd, input int base = SHORT_CYC, input int adv = 1,
                      input logic [3:0] ind = 0, input logic [15:0] nw = 0);
      int c;
      int e;
      issue(wd, ind, nw);
      wait_fetch(c);
      e = 2 + base + IND_CYC * ind;
      samples_checked++;
      if (c < e - 2 || c > e + 2) begin
         errors++;
         $display("unexpected duration expected %0d seen %0d", e, c);
      end
      p = p + 15'(adv);
      chk("next addr", {9'h0, p}, {9'h0, o_fetch_addr});
      chk("busy", 24'h0, {23'h0, o_busy});
   endtask
   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   task automatic t_enter;
      run(w(FC_ENTER, VAR_ACC, 15'h7fff));
      chk("acc", 24'h007fff, o_regs.acc);
      run(w(FC_ENTER, VAR_ACC_S, 15'h4001), SHORT_CYC, 1, 2);
      chk("acc", 24'hffc001, o_regs.acc);
      run(w(FC_ENTER, VAR_AUX, 15'h0123));
      chk("aux", 24'h000123, o_regs.aux);
      run(w(FC_ENTER, 3'h1, 15'h0010));
      chk("idx1", 24'h000010, {9'h0, o_regs.idx1});
   endtask
   task automatic t_logic;
      run(w(FC_INCREASE, VAR_ACC, 15'h0003));
      chk("acc", 24'hffc004, o_regs.acc);
      run(w(FC_XOR, VAR_ACC, 15'h00ff));
      chk("acc", 24'hffc0fb, o_regs.acc);
      run(w(FC_AND, VAR_ACC, 15'h0f0f));
      chk("acc", 24'h00000b, o_regs.acc);
      run(w(FC_XOR, 3'h1, 15'h0011));
      chk("idx1", 24'h000001, {9'h0, o_regs.idx1});
      run(w(FC_AND, VAR_AUX, 15'h0003));
      chk("aux", 24'h000003, o_regs.aux);
   endtask
   task automatic t_skip;
      run(w(FC_EQ_SKIP, VAR_ACC, 15'h000b), SKIP_CYC, 2);
      run(w(FC_EQ_SKIP, VAR_ACC, 15'h000c), SKIP_CYC);
      run(w(FC_GE_SKIP, VAR_ACC, 15'h000a), SKIP_CYC, 2);
      run(w(FC_GE_SKIP, VAR_AUX, 15'h0004), SKIP_CYC);
      run(w(FC_EQ_SKIP, 3'h1, 15'h0001), SKIP_CYC, 2);
   endtask
   task automatic t_char;
      run({FC_CHAR_LOAD, 1'b0, 17'h1abcd});
      chk("acc", 24'h01abcd, o_regs.acc);
      run({FC_CHAR_LOAD, 1'b1, 17'h10000});
      chk("acc", 24'hff0000, o_regs.acc);
   endtask
   task automatic t_step;
      run({FC_IDX_STEP, 1'b0, 2'h1, 15'h0005}, SKIP_CYC);
      chk("idx1", 24'h000002, {9'h0, o_regs.idx1});
      run({FC_IDX_STEP, 1'b1, 2'h1, 15'h0007}, SKIP_CYC);
      chk("idx1", 24'h000001, {9'h0, o_regs.idx1});
      run({FC_IDX_STEP, 1'b0, 2'h1, 15'h0001}, SKIP_CYC, 2);
      chk("idx1", 24'h000000, {9'h0, o_regs.idx1});
   endtask
   task automatic t_search;
      run(w(FC_MASK_EQ, 3'h0, 15'h0), SEARCH_CYC * 3, 1, 0, 2);
      run(w(FC_MASK_TH, 3'h0, 15'h0), SEARCH_CYC);
   endtask
   task automatic t_trap;
      int c;
      int t0;
      t0 = ntrap;
      issue(w(FC_TRAP_LO, 3'h0, 15'h0), 0, 0);
      wait_fetch(c);
      chk("trap count", 24'h1, 24'(ntrap - t0));
      chk("vector", {9'h0, TRAP_VECTOR}, {9'h0, o_fetch_addr});
      p = TRAP_VECTOR;
      i_opt_hw_present = 1'b1;
      repeat (6) @(negedge i_core_clk);
      run(w(FC_TRAP_LO, 3'h0, 15'h0));
      chk("trap count", 24'h1, 24'(ntrap - t0));
   endtask
   task automatic t_ext;
      int c;
      int n0;
      issue(w(FC_EXT_IO, 3'h0, 15'h0), 0, 0);
      n0 = nfetch;
      c = 0;
      while (o_ext_wait !== 1'b1 && c < 100) begin
         @(negedge i_core_clk);
         c++;
      end
      repeat (20) @(negedge i_core_clk);
      chk("ext wait", 24'h1, {23'h0, o_ext_wait});
      chk("fetch count", 24'h0, 24'(nfetch - n0));
      i_ext_resp = 1'b1;
      wait_fetch(c);
      chk("next address", {9'h0, p + 15'h1}, {9'h0, o_fetch_addr});
      p = p + 1;
      i_ext_resp = 1'b0;
   endtask
   task automatic t_halt;
      int c;
      int n0;
      issue(w(FC_HALT, 3'h0, 15'h0123), 0, 0);
      n0 = nfetch;
      repeat (40) @(negedge i_core_clk);
      chk("halted", 24'h1, {23'h0, o_halted});
      chk("fetch count", 24'h0, 24'(nfetch - n0));
      i_restart = 1'b1;
      repeat (4) @(negedge i_core_clk);
      i_restart = 1'b0;
      wait_fetch(c);
      chk("resume address", 24'h000123, {9'h0, o_fetch_addr});
      chk("halted", 24'h0, {23'h0, o_halted});
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      end_sim();
   end
   // main sequence
   initial begin
      int c;
      i_core_clk = 0;
      i_rstn = 0;
      i_instr_valid = 0;
      i_opt_hw_present = 0;
      i_ext_resp = 0;
      i_restart = 0;
      p = 15'h0;
      repeat (8) @(negedge i_core_clk);
      i_rstn = 1;
      wait_fetch(c);
      chk("reset address", 24'h0, {9'h0, o_fetch_addr});
      chk("acc", 24'h0, o_regs.acc);
      t_enter();
      t_logic();
      t_skip();
      t_char();
      t_step();
      t_search();
      t_trap();
      t_ext();
      t_halt();
      end_sim();
   end
endmodule
`default_nettype wire
